// ==== rtl/status_bank_defs.svh ====
`ifndef STATUS_BANK_DEFS_SVH
`define STATUS_BANK_DEFS_SVH

// width of every status register in the bank
`define REG_WIDTH        16
// number of calculation windows and sensors
`define WINDOW_COUNT     8
`define SENSOR_COUNT     4
// error code width and values as reported by sensors and calc blocks
`define ERR_CODE_WIDTH   16
`define ERR_DATA_STALE   16'hff1a
`define ERR_DATA_DOUBT   16'hff19
// field positions
`define WINDOW_LSB       1
`define WINDOW_MSB       8
`define SENSOR_DATA_LSB  1
`define SENSOR_DATA_MSB  4
`define SENSOR_ZERO_LSB  5
`define SENSOR_ZERO_MSB  8
// bits that carry meaning in any register of the bank (1 to 8)
`define USED_BITS        16'h01fe
// reset values
`define COND_RESET       16'h0000
`define EVENT_RESET      16'h0000
`define MASK_RESET       16'h0000

`endif

// ==== rtl/status_bank_pkg.sv ====
`default_nettype none

package status_bank_pkg;

  // query selector: which part of which register is read
  typedef enum logic [2:0] {
    SEL_LOW_LIVE,
    SEL_LOW_LATCHED,
    SEL_HIGH_LIVE,
    SEL_HIGH_LATCHED,
    SEL_SENSOR_LIVE,
    SEL_SENSOR_LATCHED,
    SEL_VIEW_LIVE,
    SEL_VIEW_LATCHED
  } query_sel_t;

  typedef logic [15:0] status_word_t;

endpackage

`default_nettype wire

// ==== rtl/limit_and_quality_status_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "status_bank_defs.svh"

module limit_and_quality_status_regs (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  input  wire logic [7:0]                    window_below_low_in,
  input  wire logic [7:0]                    window_above_high_in,
  input  wire logic                          low_bound_check_switch_in,
  input  wire logic                          high_bound_check_switch_in,
  input  wire logic [7:0]                    low_enable_mask_in,
  input  wire logic [7:0]                    high_enable_mask_in,
  input  wire logic [3:0]                    sensor_err_valid_in,
  input  wire logic [3:0][15:0]              sensor_err_code_in,
  input  wire logic [3:0]                    sensor_zero_stale_in,
  input  wire logic [7:0]                    calc_err_valid_in,
  input  wire logic [7:0][15:0]              calc_err_code_in,
  input  wire logic [15:0]                   sensor_rising_edge_mask_in,
  input  wire logic [15:0]                   sensor_falling_edge_mask_in,
  input  wire logic [15:0]                   view_rising_edge_mask_in,
  input  wire logic [15:0]                   view_falling_edge_mask_in,
  input  wire logic                          query_strobe_in,
  input  wire status_bank_pkg::query_sel_t   query_sel_in,
  output logic [15:0]                        query_data_out,
  output logic                               query_valid_out,
  output logic                               low_bound_summary_out,
  output logic                               high_bound_summary_out
);

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------

  // transition filter: rising and falling changes through their masks
  function automatic status_bank_pkg::status_word_t edge_hits(
    input status_bank_pkg::status_word_t prev,
    input status_bank_pkg::status_word_t cur,
    input status_bank_pkg::status_word_t rise,
    input status_bank_pkg::status_word_t fall
  );
    edge_hits = ((~prev & cur & rise) | (prev & ~cur & fall)) & `USED_BITS;
  endfunction

  // error code check for questionable or stale data
  function automatic logic is_bad_code(input logic [15:0] code, input logic allow_stale);
    is_bad_code = (code == `ERR_DATA_DOUBT) || (allow_stale && (code == `ERR_DATA_STALE));
  endfunction

  // ------------------------------------------------------------
  // live condition parts
  // ------------------------------------------------------------

  status_bank_pkg::status_word_t low_live;
  status_bank_pkg::status_word_t high_live;
  status_bank_pkg::status_word_t sensor_live;
  status_bank_pkg::status_word_t view_live;
  status_bank_pkg::status_word_t next_sensor_live;
  status_bank_pkg::status_word_t next_view_live;

  // decode sensor and calc-block error reports into flag bits
  always_comb begin
    next_sensor_live = `COND_RESET;
    next_view_live   = `COND_RESET;
    for (int s = 0; s < `SENSOR_COUNT; s++) begin
      next_sensor_live[`SENSOR_DATA_LSB + s] = sensor_err_valid_in[s] && is_bad_code(sensor_err_code_in[s], 1'b1);
      next_sensor_live[`SENSOR_ZERO_LSB + s] = sensor_zero_stale_in[s];
    end
    for (int w = 0; w < `WINDOW_COUNT; w++) begin
      next_view_live[`WINDOW_LSB + w] = calc_err_valid_in[w] && is_bad_code(calc_err_code_in[w], 1'b0);
    end
  end

  // limit comparisons land in bits 1 to 8, others stay zero
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_live  <= `COND_RESET;
      high_live <= `COND_RESET;
    end else begin
      low_live  <= {7'h00, window_below_low_in, 1'b0};
      high_live <= {7'h00, window_above_high_in, 1'b0};
    end
  end

  // questionable condition parts
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sensor_live <= `COND_RESET;
      view_live   <= `COND_RESET;
    end else begin
      sensor_live <= next_sensor_live & `USED_BITS;
      view_live   <= next_view_live & `USED_BITS;
    end
  end

  // ------------------------------------------------------------
  // transition masks of the limit groups
  // ------------------------------------------------------------

  status_bank_pkg::status_word_t low_rise_mask;
  status_bank_pkg::status_word_t low_fall_mask;
  status_bank_pkg::status_word_t high_rise_mask;
  status_bank_pkg::status_word_t high_fall_mask;

  // switching a check on arms the rising mask on all windows
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_rise_mask  <= `MASK_RESET;
      low_fall_mask  <= `MASK_RESET;
      high_rise_mask <= `MASK_RESET;
      high_fall_mask <= `MASK_RESET;
    end else begin
      low_rise_mask  <= low_bound_check_switch_in ? `USED_BITS : `MASK_RESET;
      low_fall_mask  <= `MASK_RESET;
      high_rise_mask <= high_bound_check_switch_in ? `USED_BITS : `MASK_RESET;
      high_fall_mask <= `MASK_RESET;
    end
  end

  // ------------------------------------------------------------
  // previous conditions and transition hits
  // ------------------------------------------------------------

  status_bank_pkg::status_word_t low_prev;
  status_bank_pkg::status_word_t high_prev;
  status_bank_pkg::status_word_t sensor_prev;
  status_bank_pkg::status_word_t view_prev;
  status_bank_pkg::status_word_t low_hits;
  status_bank_pkg::status_word_t high_hits;
  status_bank_pkg::status_word_t sensor_hits;
  status_bank_pkg::status_word_t view_hits;

  // last cycle's conditions, for edge detection
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_prev    <= `COND_RESET;
      high_prev   <= `COND_RESET;
      sensor_prev <= `COND_RESET;
      view_prev   <= `COND_RESET;
    end else begin
      low_prev    <= low_live;
      high_prev   <= high_live;
      sensor_prev <= sensor_live;
      view_prev   <= view_live;
    end
  end

  assign low_hits    = edge_hits(low_prev, low_live, low_rise_mask, low_fall_mask);
  assign high_hits   = edge_hits(high_prev, high_live, high_rise_mask, high_fall_mask);
  assign sensor_hits = edge_hits(sensor_prev, sensor_live, sensor_rising_edge_mask_in, sensor_falling_edge_mask_in);
  assign view_hits   = edge_hits(view_prev, view_live, view_rising_edge_mask_in, view_falling_edge_mask_in);

  // ------------------------------------------------------------
  // latched event parts
  // ------------------------------------------------------------

  status_bank_pkg::status_word_t low_latched;
  status_bank_pkg::status_word_t high_latched;
  status_bank_pkg::status_word_t sensor_latched;
  status_bank_pkg::status_word_t view_latched;
  logic                          rd_low;
  logic                          rd_high;
  logic                          rd_sensor;
  logic                          rd_view;

  // which event part is read and so cleared this cycle
  assign rd_low    = query_strobe_in && (query_sel_in == status_bank_pkg::SEL_LOW_LATCHED);
  assign rd_high   = query_strobe_in && (query_sel_in == status_bank_pkg::SEL_HIGH_LATCHED);
  assign rd_sensor = query_strobe_in && (query_sel_in == status_bank_pkg::SEL_SENSOR_LATCHED);
  assign rd_view   = query_strobe_in && (query_sel_in == status_bank_pkg::SEL_VIEW_LATCHED);

  // sticky events, a new hit wins over a clearing read
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_latched    <= `EVENT_RESET;
      high_latched   <= `EVENT_RESET;
      sensor_latched <= `EVENT_RESET;
      view_latched   <= `EVENT_RESET;
    end else begin
      low_latched    <= (rd_low ? `EVENT_RESET : low_latched) | low_hits;
      high_latched   <= (rd_high ? `EVENT_RESET : high_latched) | high_hits;
      sensor_latched <= (rd_sensor ? `EVENT_RESET : sensor_latched) | sensor_hits;
      view_latched   <= (rd_view ? `EVENT_RESET : view_latched) | view_hits;
    end
  end

  // ------------------------------------------------------------
  // query answer and summary bits
  // ------------------------------------------------------------

  status_bank_pkg::status_word_t next_query_data;

  // select the addressed part
  always_comb begin
    case (query_sel_in)
      status_bank_pkg::SEL_LOW_LIVE:       next_query_data = low_live;
      status_bank_pkg::SEL_LOW_LATCHED:    next_query_data = low_latched;
      status_bank_pkg::SEL_HIGH_LIVE:      next_query_data = high_live;
      status_bank_pkg::SEL_HIGH_LATCHED:   next_query_data = high_latched;
      status_bank_pkg::SEL_SENSOR_LIVE:    next_query_data = sensor_live;
      status_bank_pkg::SEL_SENSOR_LATCHED: next_query_data = sensor_latched;
      status_bank_pkg::SEL_VIEW_LIVE:      next_query_data = view_live;
      status_bank_pkg::SEL_VIEW_LATCHED:   next_query_data = view_latched;
      default:                             next_query_data = `COND_RESET;
    endcase
  end

  // answer one cycle after the strobe, held until the next strobe
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      query_data_out  <= `COND_RESET;
      query_valid_out <= 1'b0;
    end else begin
      query_valid_out <= query_strobe_in;
      if (query_strobe_in) begin
        query_data_out <= next_query_data & `USED_BITS;
      end
    end
  end

  // summaries toward the parent operation register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      low_bound_summary_out  <= 1'b0;
      high_bound_summary_out <= 1'b0;
    end else begin
      low_bound_summary_out  <= |(low_latched[`WINDOW_MSB:`WINDOW_LSB] & low_enable_mask_in);
      high_bound_summary_out <= |(high_latched[`WINDOW_MSB:`WINDOW_LSB] & high_enable_mask_in);
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_low_live_map: assert property (##1 low_live == {7'h00, $past(window_below_low_in), 1'b0})
    else $error("lower live bits do not follow windows");
  a_high_live_map: assert property (##1 high_live == {7'h00, $past(window_above_high_in), 1'b0})
    else $error("upper live bits do not follow windows");
  a_low_event_hold: assert property ((|low_hits) |=> ((low_latched & $past(low_hits)) == $past(low_hits)))
    else $error("lower event lost");
  a_high_event_hold: assert property ((|high_hits) |=> ((high_latched & $past(high_hits)) == $past(high_hits)))
    else $error("upper event lost");
  a_low_fall_event: assert property (
    low_bound_check_switch_in ##1 (low_bound_check_switch_in && $rose(low_live[1])) |=> low_latched[1])
    else $error("fall below lower bound not latched");
  a_high_rise_event: assert property (
    high_bound_check_switch_in ##1 (high_bound_check_switch_in && $rose(high_live[8])) |=> high_latched[8])
    else $error("exceeding upper bound not latched");
  a_unused_zero: assert property (
    ((low_latched | high_latched | sensor_latched | view_latched | query_data_out) & ~`USED_BITS) == 16'h0000)
    else $error("unused bit set");
  a_corrupt_set: assert property (
    (sensor_err_valid_in[0] && sensor_err_code_in[0] == `ERR_DATA_STALE) |=> sensor_live[1])
    else $error("stale code did not flag sensor");
  a_zero_map: assert property (##1 sensor_live[8:5] == $past(sensor_zero_stale_in))
    else $error("zero request bits wrong");
  a_view_flag: assert property (
    ##1 view_live[8:1] == $past(calc_err_valid_in & {
      calc_err_code_in[7] == `ERR_DATA_DOUBT, calc_err_code_in[6] == `ERR_DATA_DOUBT,
      calc_err_code_in[5] == `ERR_DATA_DOUBT, calc_err_code_in[4] == `ERR_DATA_DOUBT,
      calc_err_code_in[3] == `ERR_DATA_DOUBT, calc_err_code_in[2] == `ERR_DATA_DOUBT,
      calc_err_code_in[1] == `ERR_DATA_DOUBT, calc_err_code_in[0] == `ERR_DATA_DOUBT}))
    else $error("view bits do not follow calc errors");
  a_fall_record: assert property (
    (sensor_prev[1] && !sensor_live[1] && sensor_falling_edge_mask_in[1]) |=> sensor_latched[1])
    else $error("falling change not recorded");
  a_read_clear: assert property (
    (rd_low && low_hits == 16'h0000) |=>
      (query_data_out == $past(low_latched) && low_latched == 16'h0000 && query_valid_out))
    else $error("event read did not return and clear");
  a_summary: assert property (##1 low_bound_summary_out == $past(|(low_latched[8:1] & low_enable_mask_in)))
    else $error("lower summary wrong");

  c_low_event: cover property (low_bound_check_switch_in && low_hits[1]);
  c_read_clear: cover property (rd_high && high_latched != 16'h0000);
  c_set_with_read: cover property (rd_sensor && sensor_hits != 16'h0000);

endmodule

`default_nettype wire

// ==== tb/query_master.sv ====
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// remote controller issuing status queries
// ----------------------------------------
module query_master (
  input  wire logic                  clk_in,
  output logic                       query_strobe_out,
  output status_bank_pkg::query_sel_t query_sel_out
);

  // idle at time zero
  initial begin
    query_strobe_out = 1'b0;
    query_sel_out    = status_bank_pkg::SEL_LOW_LIVE;
  end

  // one-cycle query, then the select is scrambled so a stale value cannot match
  task automatic query(input status_bank_pkg::query_sel_t sel);
    @(posedge clk_in);
    #1;
    query_strobe_out = 1'b1;
    query_sel_out    = sel;
    @(posedge clk_in);
    #1;
    query_strobe_out = 1'b0;
    query_sel_out    = status_bank_pkg::query_sel_t'(~sel);
  endtask

endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic              clk_in, reset_in, low_sw, high_sw, strobe, qvalid, low_sum, high_sum;
  logic [7:0]        below, above, low_en, high_en, calc_valid, v, en;
  logic [3:0]        sens_valid, zero;
  logic [3:0][15:0]  sens_code;
  logic [7:0][15:0]  calc_code;
  logic [15:0]       s_rise, s_fall, v_rise, v_fall, qdata, rnd;
  status_bank_pkg::query_sel_t qsel;
  logic [15:0]       exp_q[$];
  status_bank_pkg::query_sel_t sel_q[$];
  int                err_count, total_checks, cycles;

  limit_and_quality_status_regs u_limit_and_quality_status_regs (
    .clk_in(clk_in), .reset_in(reset_in), .window_below_low_in(below), .window_above_high_in(above),
    .low_bound_check_switch_in(low_sw), .high_bound_check_switch_in(high_sw),
    .low_enable_mask_in(low_en), .high_enable_mask_in(high_en), .sensor_err_valid_in(sens_valid),
    .sensor_err_code_in(sens_code), .sensor_zero_stale_in(zero), .calc_err_valid_in(calc_valid),
    .calc_err_code_in(calc_code), .sensor_rising_edge_mask_in(s_rise), .sensor_falling_edge_mask_in(s_fall),
    .view_rising_edge_mask_in(v_rise), .view_falling_edge_mask_in(v_fall), .query_strobe_in(strobe),
    .query_sel_in(qsel), .query_data_out(qdata), .query_valid_out(qvalid),
    .low_bound_summary_out(low_sum), .high_bound_summary_out(high_sum));

  query_master u_query_master (.clk_in(clk_in), .query_strobe_out(strobe), .query_sel_out(qsel));

  // clock, 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // xorshift source of stimulus
  function automatic logic [15:0] xs(input logic [15:0] s);
    logic [15:0] x;
    x = s ^ (s << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  task automatic next_rnd();
    rnd = xs(rnd);
  endtask

  // verdict and end of run
  task automatic give_verdict();
    // a query that never got its answer is a mismatch too
    if (exp_q.size() != 0) begin
      err_count++;
      $display("Error pending answers expected 0 seen %0d", exp_q.size());
    end
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // note the expected answer, then issue the query
  task automatic rd(input status_bank_pkg::query_sel_t sel, input logic [15:0] exp);
    exp_q.push_back(exp);
    sel_q.push_back(sel);
    u_query_master.query(sel);
  endtask

  task automatic chk_bit(input string name, input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %b seen %b", name, exp, seen);
    end
  endtask

  // monitor: every answer is matched to the oldest note
  always @(negedge clk_in) begin
    if (qvalid === 1'b1) begin
      total_checks++;
      if (exp_q.size() == 0) begin
        err_count++;
        $display("Error unexpected answer expected none seen %h", qdata);
      end else if (qdata !== exp_q[0]) begin
        err_count++;
        $display("Error %s expected %h seen %h", sel_q[0].name(), exp_q[0], qdata);
      end
      if (exp_q.size() != 0) begin
        void'(exp_q.pop_front());
        void'(sel_q.pop_front());
      end
    end
  end

  // hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      $display("Error timeout expected done seen hang");
      give_verdict();
    end
  end

  // one limit group: live, latched, read-clear, no fall event, switch off
  task automatic limit_test(input logic hi);
    status_bank_pkg::query_sel_t live_sel;
    status_bank_pkg::query_sel_t ev_sel;
    logic [15:0] w;
    live_sel = hi ? status_bank_pkg::SEL_HIGH_LIVE : status_bank_pkg::SEL_LOW_LIVE;
    ev_sel   = hi ? status_bank_pkg::SEL_HIGH_LATCHED : status_bank_pkg::SEL_LOW_LATCHED;
    next_rnd();
    v  = rnd[7:0] | 8'h81;
    en = rnd[15:8] | 8'h01;
    w  = {7'h00, v, 1'b0};
    if (hi) high_sw = 1'b1; else low_sw = 1'b1;
    if (hi) high_en = en; else low_en = en;
    cyc(2);
    if (hi) above = v; else below = v; // bounds set before flags used
    cyc(4);
    chk_bit("summary", hi ? high_sum : low_sum, |(v & en));
    rd(live_sel, w);
    rd(live_sel, w);
    rd(ev_sel, w);
    rd(ev_sel, 16'h0000);
    if (hi) above = 8'h00; else below = 8'h00;
    cyc(4);
    rd(ev_sel, 16'h0000);
    if (hi) high_sw = 1'b0; else low_sw = 1'b0;
    cyc(2);
    if (hi) above = v; else below = v;
    cyc(4);
    rd(ev_sel, 16'h0000);
    rd(live_sel, w);
    if (hi) above = 8'h00; else below = 8'h00;
    $display("test limit group %0d done", hi);
  endtask

  initial begin
    {low_sw, high_sw, below, above, low_en, high_en, calc_valid, sens_valid, zero} = '0;
    {sens_code, calc_code, s_rise, s_fall, v_rise, v_fall} = '0;
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    rnd = 16'h005e;
    reset_in = 1'b1;
    repeat (5) @(posedge clk_in);
    #1;
    reset_in = 1'b0;
    for (int s = 0; s < 8; s++) rd(status_bank_pkg::query_sel_t'(s), 16'h0000);
    $display("test reset values done");
    limit_test(1'b0);
    limit_test(1'b1);
    // questionable sensor: stale, doubtful, other code, unreported doubtful
    s_rise = 16'hffff;
    cyc(2);
    next_rnd();
    zero = rnd[3:0];
    sens_code[0] = `ERR_DATA_STALE;
    sens_code[1] = `ERR_DATA_DOUBT;
    sens_code[2] = 16'h0001;
    sens_code[3] = `ERR_DATA_DOUBT;
    sens_valid = 4'b0111;
    cyc(4);
    rd(status_bank_pkg::SEL_SENSOR_LIVE, {7'h00, zero, 4'b0011, 1'b0});
    rd(status_bank_pkg::SEL_SENSOR_LATCHED, {7'h00, zero, 4'b0011, 1'b0});
    // only falls recorded now
    s_rise = 16'h0000;
    s_fall = 16'hffff;
    cyc(2);
    sens_valid = 4'b0000;
    zero = 4'h0;
    cyc(4);
    rd(status_bank_pkg::SEL_SENSOR_LATCHED, {7'h00, rnd[3:0], 4'b0011, 1'b0});
    rd(status_bank_pkg::SEL_SENSOR_LIVE, 16'h0000);
    $display("test sensor done");
    // questionable view: only the doubtful code flags a window
    v_rise = 16'hffff;
    for (int i = 0; i < 8; i++) calc_code[i] = i[0] ? `ERR_DATA_STALE : `ERR_DATA_DOUBT;
    cyc(2);
    next_rnd();
    calc_valid = rnd[7:0];
    cyc(4);
    rd(status_bank_pkg::SEL_VIEW_LIVE, {7'h00, rnd[7:0] & 8'h55, 1'b0});
    rd(status_bank_pkg::SEL_VIEW_LATCHED, {7'h00, rnd[7:0] & 8'h55, 1'b0});
    rd(status_bank_pkg::SEL_VIEW_LATCHED, 16'h0000);
    $display("test view done");
    cyc(3);
    give_verdict();
  end
endmodule
`default_nettype wire
